// ### rtl/dsz_guard.sv
`timescale 1ns/1ps
`default_nettype none

module dsz_guard (
   input  wire logic                   clock_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   serial_bit_clock_i,
   input  wire logic                   word_frame_clock_i,
   input  wire logic                   serial_data_i,
   input  wire logic                   mute_request_in_i,
   input  wire dsz_pkg::dsz_mode_e     mode_pin_i,
   input  wire logic [3:0]             shared_pin_i,
   input  wire dsz_pkg::dsz_cfg_s      cfg_i,
   input  wire dsz_pkg::dsz_width_e    width_sel_i,
   input  wire logic                   frame_lj_i,
   input  wire logic                   quad_rate_i,
   input  wire logic                   sda_pull_low_i,
   input  wire logic                   out_ready_i,
   output logic                        out_valid_o,
   output dsz_pkg::dsz_frame_s         out_frame_o,
   output logic                        overrun_o,
   output logic                        zero_flag_one_o,
   output logic                        zero_flag_two_o,
   output logic                        zero_flag_two_oe_o,
   output logic                        centre_level_o,
   output logic                        dac_power_down_o,
   output logic                        sync_locked_o,
   output dsz_pkg::dsz_mode_e          mode_o,
   output dsz_pkg::dsz_ctl_pins_s      ctl_pins_o,
   output logic                        sda_o,
   output logic                        sda_oe_o
);

   localparam int unsigned FW = dsz_pkg::FRAME_CNT_W;
   localparam int unsigned BW = dsz_pkg::BIT_PER_W;
   localparam int unsigned HW = dsz_pkg::HOLD_W;
   localparam int unsigned AW = dsz_pkg::ASYNC_W;
   localparam int unsigned SW = dsz_pkg::SLOT_W;

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; no reset so they track the pins during reset
   logic [AW-1:0] sync1_q;
   logic [AW-1:0] sync2_q;

   always_ff @(posedge clock_i) begin
      sync1_q <= {mode_pin_i, shared_pin_i, mute_request_in_i,
                  serial_data_i, word_frame_clock_i, serial_bit_clock_i};
      sync2_q <= sync1_q;
   end

   wire                 bitclk_s = sync2_q[0];
   wire                 wclk_s   = sync2_q[1];
   wire                 sdata_s  = sync2_q[2];
   wire                 mute_rq_n_s = sync2_q[3];
   wire [3:0]           shared_s = sync2_q[7:4];
   dsz_pkg::dsz_mode_e  mode_s;
   assign mode_s = dsz_pkg::dsz_mode_e'(sync2_q[9:8]);

   logic bitclk_prev_q;
   logic wclk_prev_q;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         bitclk_prev_q <= 1'b0;
         wclk_prev_q   <= 1'b0;
      end else begin
         bitclk_prev_q <= bitclk_s;
         wclk_prev_q   <= wclk_s;
      end
   end

   wire bit_rise  = bitclk_s & ~bitclk_prev_q;
   wire wclk_rise = wclk_s & ~wclk_prev_q;

   //////////////////////////////////////////////////////////////////////////
   // Mode strap and configuration
   logic               take_mode_q;
   dsz_pkg::dsz_mode_e mode_q;
   dsz_pkg::dsz_cfg_s  cfg_q;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         take_mode_q <= 1'b1;
         mode_q      <= dsz_pkg::MODE_I2C;
         cfg_q       <= dsz_pkg::CFG_RESET;
      end else begin
         take_mode_q <= 1'b0;
         cfg_q       <= cfg_i;
         if (take_mode_q) begin
            mode_q <= mode_s;
         end
      end
   end

   wire pin_mode = mode_q == dsz_pkg::MODE_PIN;
   wire i2c_mode = mode_q == dsz_pkg::MODE_I2C;
   wire spi_mode = ~pin_mode & ~i2c_mode;
   wire frame_lj = pin_mode ? shared_s[1] : frame_lj_i;
   wire combo_b  = cfg_q.combo_b & ~pin_mode;

   // Shared pins by interface mode
   dsz_pkg::dsz_ctl_pins_s ctl_d;
   assign ctl_d.ser_data   = spi_mode & shared_s[0];
   assign ctl_d.ser_clock  = spi_mode & shared_s[1];
   assign ctl_d.ser_select = spi_mode & shared_s[2];
   assign ctl_d.reg_a5     = spi_mode & shared_s[3];
   assign ctl_d.reg_a6     = mode_q == dsz_pkg::MODE_SPI_A1;
   assign ctl_d.sda_in     = i2c_mode & shared_s[0];
   assign ctl_d.scl_in     = i2c_mode & shared_s[1];
   assign ctl_d.slave_a0   = i2c_mode & shared_s[2];
   assign ctl_d.slave_a1   = i2c_mode & shared_s[3];
   assign ctl_d.deemph_on  = pin_mode & shared_s[0];
   assign ctl_d.frame_lj   = frame_lj;

   // Open-drain data line only in two-wire mode
   assign sda_o    = 1'b0;
   assign sda_oe_o = i2c_mode & sda_pull_low_i;

   //////////////////////////////////////////////////////////////////////////
   // Serial receiver; samples kept MSB-aligned in a 32-bit slot
   logic          wclk_slot_q;
   logic [SW-1:0] shift_q;
   logic [5:0]    bitpos_q;
   logic [SW-1:0] left_hold_q;

   wire          slot_flip = bit_rise & (wclk_s != wclk_slot_q);
   wire [SW-1:0] bit_set   = (bitpos_q < 6'h20)
                             ? (dsz_pkg::SLOT_MSB >> bitpos_q) : '0;
   wire [SW-1:0] with_bit  = sdata_s ? (shift_q | bit_set) : shift_q;
   // I2S: bit at the flip still belongs to the old slot
   wire [SW-1:0] done_word = frame_lj ? shift_q : with_bit;
   wire          done_left = frame_lj ? wclk_slot_q : ~wclk_slot_q;
   wire          pair_done = slot_flip & ~done_left;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wclk_slot_q <= 1'b0;
         shift_q     <= '0;
         bitpos_q    <= '0;
         left_hold_q <= '0;
      end else if (bit_rise) begin
         wclk_slot_q <= wclk_s;
         if (slot_flip) begin
            shift_q  <= (frame_lj & sdata_s) ? dsz_pkg::SLOT_MSB : '0;
            bitpos_q <= frame_lj ? 6'h01 : 6'h00;
            if (done_left) begin
               left_hold_q <= done_word;
            end
         end else begin
            shift_q <= with_bit;
            if (bitpos_q != 6'h3F) begin
               bitpos_q <= bitpos_q + 6'h01;
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pending pair waits on the buffer; a late pair overwrites it
   logic                pend_valid_q;
   dsz_pkg::dsz_frame_s pend_q;
   logic                overrun_q;
   logic                buf_ready;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pend_valid_q <= 1'b0;
         pend_q       <= '0;
         overrun_q    <= 1'b0;
      end else begin
         overrun_q <= pair_done & pend_valid_q & ~buf_ready;
         if (pair_done) begin
            pend_valid_q <= 1'b1;
            pend_q       <= '{left: left_hold_q, right: done_word};
         end else if (buf_ready) begin
            pend_valid_q <= 1'b0;
         end
      end
   end

   assign overrun_o = overrun_q;

   dsz_pair_buf #(
      .WIDTH ($bits(dsz_pkg::dsz_frame_s)),
      .DEPTH (dsz_pkg::BUF_DEPTH)
   ) u_buf (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (pend_valid_q),
      .in_ready_o  (buf_ready),
      .in_data_i   (pend_q),
      .out_valid_o (out_valid_o),
      .out_ready_i (out_ready_i),
      .out_data_o  (out_frame_o)
   );

   //////////////////////////////////////////////////////////////////////////
   // Zero detection per channel
   logic [SW-1:0] chan_word [2];
   logic [1:0]    chan_zero;
   logic [1:0]    zero_run;

   wire [SW-1:0] width_mask = dsz_pkg::dsz_width_mask(width_sel_i);
   wire          zero_en    = width_sel_i != dsz_pkg::WID_32;

   assign chan_word[0] = left_hold_q;
   assign chan_word[1] = done_word;

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      assign chan_zero[ch] = (chan_word[ch] & width_mask) == '0;
      dsz_zero_run u_run (
         .clock_i  (clock_i),
         .rst_n_i  (rst_n_i),
         .tick_i   (pair_done),
         .zero_i   (chan_zero[ch]),
         .enable_i (zero_en),
         .flag_o   (zero_run[ch])
      );
   end

   wire zflag1_raw = combo_b ? (zero_run[0] | zero_run[1])
                             : zero_run[0];
   wire zflag2_raw = combo_b ? (zero_run[0] & zero_run[1])
                             : zero_run[1];

   //////////////////////////////////////////////////////////////////////////
   // Frame length monitor in master-clock cycles
   logic [BW-1:0]      bitper_cnt_q;
   logic [BW-1:0]      bitper_q;
   logic [FW-1:0]      frame_cnt_q;
   logic [FW-1:0]      ref_q;
   dsz_pkg::dsz_sync_e sync_q;
   dsz_pkg::dsz_sync_e sync_d;
   logic [HW-1:0]      hold_cnt_q;
   logic [HW-1:0]      hold_d;

   wire [FW-1:0] tol = FW'(bitper_q) * FW'(dsz_pkg::SLIP_TOL_BITS);
   wire [FW:0]   ref_hi = {1'b0, ref_q} + {1'b0, tol};
   wire [FW:0]   cnt_hi = {1'b0, frame_cnt_q} + {1'b0, tol};
   // Long frame caught mid-frame, so muting never waits a full sample
   wire long_frame = {1'b0, frame_cnt_q} > ref_hi;
   wire short_frame = wclk_rise & (cnt_hi < {1'b0, ref_q});
   wire slip = long_frame | short_frame;

   wire [HW-1:0] hold_target = quad_rate_i ? dsz_pkg::HOLD_QR_FRAMES
                                           : dsz_pkg::HOLD_SR_FRAMES;
   wire [HW-1:0] hold_next = hold_cnt_q + 6'h01;
   wire          hold_done = hold_next == hold_target;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         bitper_cnt_q <= '0;
         bitper_q     <= '0;
         frame_cnt_q  <= '0;
         ref_q        <= '0;
      end else begin
         if (bit_rise) begin
            bitper_q     <= bitper_cnt_q;
            bitper_cnt_q <= 8'h01;
         end else if (bitper_cnt_q != 8'hFF) begin
            bitper_cnt_q <= bitper_cnt_q + 8'h01;
         end
         if (wclk_rise) begin
            ref_q       <= frame_cnt_q;
            frame_cnt_q <= 14'h0001;
         end else if (frame_cnt_q != 14'h3FFF) begin
            frame_cnt_q <= frame_cnt_q + 14'h0001;
         end
      end
   end

   always_comb begin
      sync_d = sync_q;
      hold_d = hold_cnt_q;
      unique case (sync_q)
         dsz_pkg::SYNC_LOST: begin
            if (wclk_rise && !slip) begin
               sync_d = dsz_pkg::SYNC_HOLD;
               hold_d = '0;
            end
         end
         dsz_pkg::SYNC_HOLD: begin
            if (slip) begin
               sync_d = dsz_pkg::SYNC_LOST;
            end else if (wclk_rise) begin
               hold_d = hold_next;
               if (hold_done) begin
                  sync_d = dsz_pkg::SYNC_RUN;
               end
            end
         end
         dsz_pkg::SYNC_RUN: begin
            if (slip) begin
               sync_d = dsz_pkg::SYNC_LOST;
            end
         end
         default: begin
            sync_d = dsz_pkg::SYNC_LOST;
         end
      endcase
   end

   // A stopped master clock freezes all state; the next frame then slips
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sync_q     <= dsz_pkg::SYNC_LOST;
         hold_cnt_q <= '0;
      end else begin
         sync_q     <= sync_d;
         hold_cnt_q <= hold_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Mute and pin outputs
   wire mute_rq  = ~mute_rq_n_s;
   wire int_mute = (sync_q != dsz_pkg::SYNC_RUN) | cfg_q.dac_disable
                   | (cfg_q.zero_mute & zero_run[0] & zero_run[1]);

   logic zflag1_q;
   logic pin2_q;
   logic pin2_oe_q;
   logic centre_q;
   logic pdown_q;
   dsz_pkg::dsz_ctl_pins_s ctl_q;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         zflag1_q  <= 1'b0;
         pin2_q    <= 1'b0;
         pin2_oe_q <= 1'b1;
         centre_q  <= 1'b1;
         pdown_q   <= 1'b0;
         ctl_q     <= '0;
      end else begin
         zflag1_q  <= zflag1_raw ^ cfg_q.pol_inv;
         pin2_q    <= cfg_q.pin_sel_mute ? 1'b0
                                         : zflag2_raw ^ cfg_q.pol_inv;
         pin2_oe_q <= cfg_q.pin_sel_mute ? int_mute : 1'b1;
         centre_q  <= mute_rq | int_mute;
         pdown_q   <= ~mute_rq & cfg_q.power_save;
         ctl_q     <= ctl_d;
      end
   end

   assign zero_flag_one_o    = zflag1_q;
   assign zero_flag_two_o    = pin2_q;
   assign zero_flag_two_oe_o = pin2_oe_q;
   assign centre_level_o     = centre_q;
   assign dac_power_down_o   = pdown_q;
   assign sync_locked_o      = sync_q == dsz_pkg::SYNC_RUN;
   assign mode_o             = mode_q;
   assign ctl_pins_o         = ctl_q;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_enter_run;
      (sync_q != dsz_pkg::SYNC_RUN) ##1 (sync_q == dsz_pkg::SYNC_RUN);
   endsequence

   a_slip_mutes: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      long_frame |-> ##2 centre_level_o && !sync_locked_o)
      else $error("slip did not force centre level");

   a_resync_hold: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      s_enter_run |-> $past(sync_q) == dsz_pkg::SYNC_HOLD
                      && $past(hold_cnt_q) + 6'h01 == $past(hold_target))
      else $error("resumed before the hold count");

   a_small_slip: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      sync_q == dsz_pkg::SYNC_RUN && !slip |=> sync_q == dsz_pkg::SYNC_RUN)
      else $error("lock lost without a slip");

   a_wide_off: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      width_sel_i == dsz_pkg::WID_32 |=> zero_run == 2'h0)
      else $error("zero flag active at 32-bit width");

   a_combo_pin: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      pin_mode |-> zflag1_raw == zero_run[0] && zflag2_raw == zero_run[1])
      else $error("pin mode not using combination A");

   a_mute_status: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      int_mute && cfg_q.pin_sel_mute |=> zero_flag_two_oe_o
                                        && !zero_flag_two_o)
      else $error("mute status not pulled low");

   a_mute_prio: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      mute_rq |=> centre_level_o && !dac_power_down_o)
      else $error("mute request did not override power-down");

   a_mode_hold: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      !take_mode_q |=> $stable(mode_o))
      else $error("mode changed after reset release");

endmodule

`default_nettype wire

// ### rtl/dsz_pair_buf.sv
`timescale 1ns/1ps
`default_nettype none

module dsz_pair_buf #(
   parameter int unsigned WIDTH = 64,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [CW-1:0]    cnt_q;

   wire push = in_valid_i & in_ready_o;
   wire pop  = out_valid_o & out_ready_i;

   assign in_ready_o  = cnt_q != CW'(DEPTH);
   assign out_valid_o = cnt_q != '0;
   assign out_data_o  = mem_q[rd_q];

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= bump(wr_q);
         end
         if (pop) begin
            rd_q <= bump(rd_q);
         end
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end

endmodule

`default_nettype wire

// ### rtl/dsz_pkg.sv
package dsz_pkg;

   localparam int unsigned SLOT_W      = 32;
   localparam int unsigned FRAME_CNT_W = 14;
   localparam int unsigned BIT_PER_W   = 8;
   localparam int unsigned ZRUN_W      = 11;
   localparam int unsigned HOLD_W      = 6;
   localparam int unsigned ASYNC_W     = 10;
   localparam int unsigned BUF_DEPTH   = 2;

   // Counts in word-clock periods
   localparam logic [ZRUN_W-1:0] ZERO_RUN_LEN   = 11'h400;
   localparam logic [HOLD_W-1:0] HOLD_SR_FRAMES = 6'h26;
   localparam logic [HOLD_W-1:0] HOLD_QR_FRAMES = 6'h1D;
   // Allowed slip in bit-clock periods
   localparam int unsigned       SLIP_TOL_BITS  = 2;

   localparam logic [SLOT_W-1:0] SLOT_MSB = 32'h8000_0000;

   typedef enum logic [1:0] {
      MODE_I2C    = 2'h0,
      MODE_PIN    = 2'h1,
      MODE_SPI_A0 = 2'h3,
      MODE_SPI_A1 = 2'h2
   } dsz_mode_e;

   typedef enum logic [1:0] {
      SYNC_LOST = 2'h0,
      SYNC_HOLD = 2'h1,
      SYNC_RUN  = 2'h3
   } dsz_sync_e;

   typedef enum logic [1:0] {
      WID_16 = 2'h0,
      WID_20 = 2'h1,
      WID_24 = 2'h2,
      WID_32 = 2'h3
   } dsz_width_e;

   typedef struct packed {
      logic [SLOT_W-1:0] left;
      logic [SLOT_W-1:0] right;
   } dsz_frame_s;

   typedef struct packed {
      logic combo_b;
      logic pol_inv;
      logic pin_sel_mute;
      logic zero_mute;
      logic dac_disable;
      logic power_save;
   } dsz_cfg_s;

   localparam dsz_cfg_s CFG_RESET = 6'h00;

   typedef struct packed {
      logic ser_data;
      logic ser_clock;
      logic ser_select;
      logic reg_a5;
      logic reg_a6;
      logic sda_in;
      logic scl_in;
      logic slave_a0;
      logic slave_a1;
      logic deemph_on;
      logic frame_lj;
   } dsz_ctl_pins_s;

   function automatic logic [SLOT_W-1:0] dsz_width_mask(input dsz_width_e w);
      unique case (w)
         WID_16: dsz_width_mask = 32'hFFFF_0000;
         WID_20: dsz_width_mask = 32'hFFFF_F000;
         WID_24: dsz_width_mask = 32'hFFFF_FF00;
         WID_32: dsz_width_mask = 32'hFFFF_FFFF;
      endcase
   endfunction

endpackage

// ### rtl/dsz_zero_run.sv
`timescale 1ns/1ps
`default_nettype none

module dsz_zero_run (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic tick_i,
   input  wire logic zero_i,
   input  wire logic enable_i,
   output logic      flag_o
);

   logic [dsz_pkg::ZRUN_W-1:0] run_q;

   assign flag_o = run_q == dsz_pkg::ZERO_RUN_LEN;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || !enable_i) begin
         run_q <= '0;
      end else if (tick_i) begin
         if (!zero_i) begin
            run_q <= '0;
         end else if (!flag_o) begin
            run_q <= run_q + 11'h001;
         end
      end
   end

   a_zero_rise: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(flag_o) |-> $past(tick_i) && $past(zero_i)
                        && $past(run_q) == 11'h3FF)
      else $error("zero flag rose without a full zero run");

   a_zero_drop: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      tick_i && !zero_i |=> !flag_o)
      else $error("zero flag kept after a nonzero sample");

   a_zero_sat: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      flag_o && enable_i && !(tick_i && !zero_i) |=> flag_o)
      else $error("zero flag dropped without a nonzero sample");

endmodule

`default_nettype wire

// ### tb/dsz_audio_src.sv
`timescale 1ns/1ps
`default_nettype none

module dsz_audio_src (
   input  wire logic        run_i,
   input  wire logic        lj_i,
   input  wire logic [63:0] pair_i,
   input  wire logic [3:0]  slip_i,
   output logic             bck_o,
   output logic             word_frame_clock_o,
   output logic             data_o
);
   logic [63:0] word_q;
   int          len;

   initial begin
      bck_o = 1'b0;
      word_frame_clock_o = 1'b0;
      data_o = 1'b0;
      // Phase offset from the master clock
      #7;
      forever begin
         // Bit clock stands still between bursts
         while (!run_i) #40;
         word_q = pair_i;
         len = 64 + slip_i;
         for (int i = 0; i < len; i++) begin
            // I2S moves the word clock one bit ahead and keeps left low
            word_frame_clock_o = lj_i ? (i < 32) : (i >= 31 && i < 63);
            data_o = (i < 64) ? word_q[63-i] : ~data_o;
            #160 bck_o = 1'b1;
            #160 bck_o = 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// ### tb/dsz_guard_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dsz_guard_tb;
   logic                   clock_i, rst_n_i, mreq, run, ordy, flj, quad;
   logic                   spl, soe;
   logic [63:0]            pair;
   logic [3:0]             slip, shp;
   dsz_pkg::dsz_mode_e     mpin, mo;
   dsz_pkg::dsz_width_e    wid;
   dsz_pkg::dsz_cfg_s      cfg;
   dsz_pkg::dsz_frame_s    frm;
   dsz_pkg::dsz_ctl_pins_s ctl;
   logic                   serial_bit_clock, word_frame_clock, sdat, vld, zf1, zf2, zoe, cen, pd, lck;
   int                     n_fail, cmp_count;

   dsz_audio_src dsz_audio_src_i (.run_i(run), .pair_i(pair), .slip_i(slip),
      .bck_o(serial_bit_clock), .word_frame_clock_o(word_frame_clock), .data_o(sdat), .lj_i(flj));

   dsz_guard dsz_guard_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .serial_bit_clock_i(serial_bit_clock), .word_frame_clock_i(word_frame_clock),
      .serial_data_i(sdat), .mute_request_in_i(mreq), .mode_pin_i(mpin),
      .shared_pin_i(shp), .cfg_i(cfg), .width_sel_i(wid),
      .frame_lj_i(flj), .quad_rate_i(quad), .sda_pull_low_i(spl),
      .out_ready_i(ordy), .out_valid_o(vld), .out_frame_o(frm),
      .overrun_o(), .zero_flag_one_o(zf1), .zero_flag_two_o(zf2),
      .zero_flag_two_oe_o(zoe), .centre_level_o(cen),
      .dac_power_down_o(pd), .sync_locked_o(lck), .mode_o(mo),
      .ctl_pins_o(ctl), .sda_o(), .sda_oe_o(soe));

   task automatic chk(input string nm, input logic [63:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #2;
   endtask

   // Bounded wait for the next word clock rise
   task automatic frame_edge;
      int k, j;
      for (k = 0; k < 900 && word_frame_clock !== 1'b0; k++) cyc(1);
      for (j = 0; j < 900 && word_frame_clock !== 1'b1; j++) cyc(1);
      if (k == 900 || j == 900) begin n_fail++; wrap_up; end
   endtask

   task automatic pop(input logic [63:0] e);
      int k;
      for (k = 0; k < 900 && vld !== 1'b1; k++) cyc(1);
      if (k == 900) begin n_fail++; wrap_up; end
      chk("frame", frm, e);
      ordy = 1'b1;
      cyc(1);
      // Let an edge pass so a following pop does not retoggle ready
      ordy = 1'b0;
      cyc(1);
   endtask

   task automatic t_mode;
      dsz_pkg::dsz_mode_e ml[4];
      ml = '{dsz_pkg::MODE_PIN, dsz_pkg::MODE_SPI_A0, dsz_pkg::MODE_SPI_A1,
             dsz_pkg::MODE_I2C};
      foreach (ml[i]) begin
         mpin = ml[i];
         rst_n_i = 1'b0;
         cyc(5);
         chk("zoe", zoe, 1);
         rst_n_i = 1'b1;
         cyc(2);
         // Strap moves after release and must be ignored
         mpin = dsz_pkg::dsz_mode_e'(~ml[i]);
         cyc(4);
         chk("mode", mo, ml[i]);
         if (i == 0) chk("deemph", ctl.deemph_on, 1);
         if (i == 0) chk("fmt", ctl.frame_lj, 1);
         if (i == 2) chk("a6", ctl.reg_a6, 1);
      end
      chk("sda", ctl.sda_in, 1);
      spl = 1'b1;
      cyc(1);
      chk("sda_oe", soe, 1);
      spl = 1'b0;
   endtask

   task automatic t_sync(input int s, input logic e);
      frame_edge;
      slip = s[3:0];
      frame_edge;
      slip = 4'h0;
      cyc(560);
      chk("slip", cen, e);
   endtask

   // Framing change slips once; quad rate then holds 29 frames, not 38
   task automatic t_i2s_quad;
      pair = 64'hA5C3_0F00_5A3C_F000;
      frame_edge;
      {flj, quad} = 2'h1;
      wid = dsz_pkg::WID_32;
      repeat (3) frame_edge;
      ordy = 1'b0;
      frame_edge;
      pop(64'hA5C3_0F00_5A3C_F000);
      ordy = 1'b1;
      wid = dsz_pkg::WID_24;
      cyc(22 * 512);
      chk("qhold", cen, 1);
      cyc(8 * 512);
      chk("qlock", {lck, cen}, 2'h2);
   endtask

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   initial begin
      {rst_n_i, run, ordy, slip, spl, n_fail, cmp_count} = '0;
      {mreq, flj, quad, shp, cfg} = {1'b1, 1'b1, 1'b0, 4'h3, 6'h00};
      mpin = dsz_pkg::MODE_I2C;
      wid = dsz_pkg::WID_24;
      pair = 64'h0102_0300_8000_0100;
      t_mode;
      run = 1'b1;
      ordy = 1'b1;
      cyc(30 * 512);
      chk("hold", cen, 1);
      cyc(12 * 512);
      chk("lock", {lck, cen}, 2'h2);
      t_sync(1, 1'b0);
      t_sync(3, 1'b1);
      cyc(42 * 512);
      frame_edge;
      pair = 64'h1234_5600_9ABC_DE00;
      frame_edge;
      pair = 64'hFEDC_BA00_0F0F_0000;
      cyc(20);
      ordy = 1'b0;
      frame_edge;
      frame_edge;
      cyc(20);
      pop(64'h1234_5600_9ABC_DE00);
      pop(64'hFEDC_BA00_0F0F_0000);
      ordy = 1'b1;
      chk("zf", {zf1, zf2}, 2'h0);
      t_i2s_quad;
      cfg.pol_inv = 1'b1;
      cyc(4);
      chk("zf_inv", {zf1, zf2}, 2'h3);
      {cfg.pol_inv, cfg.pin_sel_mute, cfg.power_save, mreq} = 4'h6;
      cyc(6);
      // External request is no internal mute cause: status stays released
      chk("mute", {cen, pd, zf2, zoe}, 4'h8);
      mreq = 1'b1;
      cyc(6);
      chk("unmute", {cen, pd, zoe}, 3'h2);
      cfg.dac_disable = 1'b1;
      cyc(6);
      chk("disable", {cen, zoe}, 2'h3);
      wrap_up;
   end
endmodule

`default_nettype wire
